// ==== verilog/one_shot_wait_pulse_mode_timer.sv ====
// One-shot wait-pulse timer with AXI4-Lite register access
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "one_shot_wait_pulse_mode_consts.svh"

module one_shot_wait_pulse_mode_timer #(
  parameter int CNT_WIDTH = 16
) (
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic        CLK_EN,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        IO_PIN_A_IN,
  output logic             IO_PIN_A_OUT,
  output logic             IO_PIN_A_OE,
  input  wire logic        EXTERNAL_COUNT_CLOCK_PIN,
  input  wire logic        FAST_OSC_40MHZ_CLOCK,
  input  wire logic        FAST_OSC_DIVIDED_CLOCK,
  output logic             WAVEFORM_PIN_B,
  output logic             MATCH_PERIOD_EVENT,
  output logic             MATCH_END_EVENT,
  output logic             MATCH_WAIT_EVENT,
  output logic             OVERFLOW_EVENT
);

  // --------------------------------------------------------------------------
  // Bus and register state
  // --------------------------------------------------------------------------
  logic                    aw_held, next_aw_held;
  logic                    w_held, next_w_held;
  logic [7:0]              aw_addr, next_aw_addr;
  logic [31:0]             w_data, next_w_data;
  logic [3:0]              w_strb, next_w_strb;
  logic                    bvalid_q, next_bvalid;
  logic [1:0]              bresp_q, next_bresp;
  logic                    rvalid_q, next_rvalid;
  logic [1:0]              rresp_q, next_rresp;
  logic [31:0]             rdata_q, next_rdata;
  logic                    run_bit, next_run_bit;
  logic                    clear_select, next_clear_select;
  logic                    b_output_level_select, next_b_output_level_select;
  logic [2:0]              count_source, next_count_source;
  logic                    stop_on_match_select, next_stop_on_match_select;
  logic [1:0]              trigger_edge_sel, next_trigger_edge_sel;
  logic [CNT_WIDTH-1:0]    period_general_reg, next_period_general_reg;
  logic [CNT_WIDTH-1:0]    end_point_general_reg, next_end_point_general_reg;
  logic [CNT_WIDTH-1:0]    wait_point_general_reg, next_wait_point_general_reg;
  logic                    port_a_data, next_port_a_data;
  logic                    port_a_drive, next_port_a_drive;
  logic                    wr_fire;
  logic [31:0]             wr_word;

  // --------------------------------------------------------------------------
  // Timer state
  // --------------------------------------------------------------------------
  logic [CNT_WIDTH-1:0]    up_counter, next_up_counter;
  logic                    counting, next_counting;
  logic                    wave_active, next_wave_active;
  logic                    wave_pin, next_wave_pin;
  logic                    trig_s1, next_trig_s1;
  logic                    trig_s2, next_trig_s2;
  logic                    trig_prev, next_trig_prev;
  logic [3:0]              events, next_events;
  logic                    tick;
  logic                    trigger_mode;
  logic                    trigger_hit;
  logic                    run_start;

  // Merge byte lanes of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction

  one_shot_wait_pulse_mode_tick_source #(
    .DIV_WIDTH (5)
  ) u_tick (
    .clk      (CLK_SYS),
    .rst      (SYS_RST),
    .ce       (CLK_EN),
    .sel      (one_shot_wait_pulse_mode_pkg::count_source_e'(count_source)),
    .ext_clk  (EXTERNAL_COUNT_CLOCK_PIN),
    .osc_fast (FAST_OSC_40MHZ_CLOCK),
    .osc_div  (FAST_OSC_DIVIDED_CLOCK),
    .tick     (tick)
  );

  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  assign AWREADY = CLK_EN && !aw_held && !bvalid_q;
  assign WREADY  = CLK_EN && !w_held && !bvalid_q;
  assign ARREADY = CLK_EN && !rvalid_q;
  assign BVALID  = bvalid_q;
  assign BRESP   = bresp_q;
  assign RVALID  = rvalid_q;
  assign RRESP   = rresp_q;
  assign RDATA   = rdata_q;
  // Write lands once both address and data are held
  assign wr_fire = CLK_EN && aw_held && w_held && !bvalid_q;
  assign wr_word = merge(32'h0000_0000, w_data, w_strb);

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid_q;
    next_bresp = bresp_q;
    next_rvalid = rvalid_q;
    next_rresp = rresp_q;
    next_rdata = rdata_q;
    next_run_bit = run_bit;
    next_clear_select = clear_select;
    next_b_output_level_select = b_output_level_select;
    next_count_source = count_source;
    next_stop_on_match_select = stop_on_match_select;
    next_trigger_edge_sel = trigger_edge_sel;
    next_period_general_reg = period_general_reg;
    next_end_point_general_reg = end_point_general_reg;
    next_wait_point_general_reg = wait_point_general_reg;
    next_port_a_data = port_a_data;
    next_port_a_drive = port_a_drive;
    if (AWVALID && AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_w_held = 1'b1;
      next_w_data = WDATA;
      next_w_strb = WSTRB;
    end
    if (CLK_EN && bvalid_q && BREADY) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `AXI_RESP_OKAY;
      if (aw_addr == `OFS_TIMER_MODE_REG) begin
        if (w_strb[0]) next_run_bit = w_data[`BIT_RUN];
      end else if (aw_addr == `OFS_TIMER_CONTROL_ONE) begin
        if (w_strb[0]) begin
          next_clear_select = w_data[`BIT_CLEAR_SELECT];
          next_count_source = w_data[`MSB_COUNT_SOURCE:`LSB_COUNT_SOURCE];
          next_b_output_level_select = w_data[`BIT_OUTPUT_LEVEL_B];
        end
      end else if (aw_addr == `OFS_TIMER_CONTROL_TWO) begin
        if (w_strb[0]) begin
          next_stop_on_match_select = w_data[`BIT_STOP_ON_MATCH];
          next_trigger_edge_sel = w_data[`MSB_TRIGGER_EDGE:`LSB_TRIGGER_EDGE];
        end
      end else if (aw_addr == `OFS_UP_COUNTER) begin
        next_bresp = `AXI_RESP_OKAY;
      end else if (aw_addr == `OFS_PERIOD_GENERAL_REG) begin
        next_period_general_reg = CNT_WIDTH'(merge(32'(period_general_reg), w_data, w_strb));
      end else if (aw_addr == `OFS_END_POINT_GENERAL_REG) begin
        next_end_point_general_reg = CNT_WIDTH'(merge(32'(end_point_general_reg), w_data,
                                                      w_strb));
      end else if (aw_addr == `OFS_WAIT_POINT_GENERAL_REG) begin
        next_wait_point_general_reg = CNT_WIDTH'(merge(32'(wait_point_general_reg), w_data,
                                                       w_strb));
      end else if (aw_addr == `OFS_PORT_A_CONTROL) begin
        if (w_strb[0]) begin
          next_port_a_data = w_data[`BIT_PORT_A_DATA];
          next_port_a_drive = w_data[`BIT_PORT_A_DRIVE];
        end
      end else if (aw_addr != `OFS_TIMER_STATUS) begin
        next_bresp = `AXI_RESP_SLVERR;
      end
    end
    if (CLK_EN && rvalid_q && RREADY) begin
      next_rvalid = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp = `AXI_RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (ARADDR == `OFS_TIMER_MODE_REG) begin
        next_rdata[`BIT_RUN] = run_bit;
      end else if (ARADDR == `OFS_TIMER_CONTROL_ONE) begin
        next_rdata[`BIT_CLEAR_SELECT] = clear_select;
        next_rdata[`MSB_COUNT_SOURCE:`LSB_COUNT_SOURCE] = count_source;
        next_rdata[`BIT_OUTPUT_LEVEL_B] = b_output_level_select;
      end else if (ARADDR == `OFS_TIMER_CONTROL_TWO) begin
        next_rdata = `FIXED_ONES_CONTROL_TWO;
        next_rdata[`BIT_STOP_ON_MATCH] = stop_on_match_select;
        next_rdata[`MSB_TRIGGER_EDGE:`LSB_TRIGGER_EDGE] = trigger_edge_sel;
      end else if (ARADDR == `OFS_UP_COUNTER) begin
        next_rdata = 32'(up_counter);
      end else if (ARADDR == `OFS_PERIOD_GENERAL_REG) begin
        next_rdata = 32'(period_general_reg);
      end else if (ARADDR == `OFS_END_POINT_GENERAL_REG) begin
        next_rdata = 32'(end_point_general_reg);
      end else if (ARADDR == `OFS_WAIT_POINT_GENERAL_REG) begin
        next_rdata = 32'(wait_point_general_reg);
      end else if (ARADDR == `OFS_PORT_A_CONTROL) begin
        next_rdata[`BIT_PORT_A_DATA] = port_a_data;
        next_rdata[`BIT_PORT_A_DRIVE] = port_a_drive;
        next_rdata[`BIT_PORT_A_LEVEL] = trig_s2;
      end else if (ARADDR == `OFS_TIMER_STATUS) begin
        next_rdata[`BIT_STATUS_COUNTING] = counting;
        next_rdata[`BIT_STATUS_WAVE] = wave_active;
      end else begin
        next_rresp = `AXI_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `AXI_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `AXI_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      run_bit <= 1'b0;
      clear_select <= 1'b0;
      b_output_level_select <= 1'b0;
      count_source <= 3'h0;
      stop_on_match_select <= 1'b0;
      trigger_edge_sel <= 2'h0;
      period_general_reg <= `GENERAL_REG_RESET;
      end_point_general_reg <= `GENERAL_REG_RESET;
      wait_point_general_reg <= `GENERAL_REG_RESET;
      port_a_data <= 1'b0;
      port_a_drive <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid_q <= next_bvalid;
      bresp_q <= next_bresp;
      rvalid_q <= next_rvalid;
      rresp_q <= next_rresp;
      rdata_q <= next_rdata;
      run_bit <= next_run_bit;
      clear_select <= next_clear_select;
      b_output_level_select <= next_b_output_level_select;
      count_source <= next_count_source;
      stop_on_match_select <= next_stop_on_match_select;
      trigger_edge_sel <= next_trigger_edge_sel;
      period_general_reg <= next_period_general_reg;
      end_point_general_reg <= next_end_point_general_reg;
      wait_point_general_reg <= next_wait_point_general_reg;
      port_a_data <= next_port_a_data;
      port_a_drive <= next_port_a_drive;
    end
  end

  // --------------------------------------------------------------------------
  // Counter and waveform; this block holds only this mode
  // --------------------------------------------------------------------------
  assign trigger_mode = (trigger_edge_sel != one_shot_wait_pulse_mode_pkg::EDGE_NONE) && stop_on_match_select;
  assign trigger_hit  = CLK_EN && (
    ((trigger_edge_sel == one_shot_wait_pulse_mode_pkg::EDGE_RISING) && trig_s2 && !trig_prev) ||
    ((trigger_edge_sel == one_shot_wait_pulse_mode_pkg::EDGE_FALLING) && !trig_s2 && trig_prev) ||
    ((trigger_edge_sel == one_shot_wait_pulse_mode_pkg::EDGE_BOTH) && (trig_s2 != trig_prev)));
  // Start by software only when the trigger path is not in use
  assign run_start = wr_fire && (aw_addr == `OFS_TIMER_MODE_REG) && w_strb[0] &&
                     w_data[`BIT_RUN] && !trigger_mode;

  always_comb begin
    next_up_counter = up_counter;
    next_counting = counting;
    next_wave_active = wave_active;
    next_trig_s1 = trig_s1;
    next_trig_s2 = trig_s2;
    next_trig_prev = trig_prev;
    next_events = 4'h0;
    next_wave_pin = wave_pin;
    if (CLK_EN) begin
      next_trig_s1 = IO_PIN_A_IN;
      next_trig_s2 = trig_s1;
      next_trig_prev = trig_s2;
      if (run_start) begin
        next_counting = 1'b1;
      end else if (!run_bit) begin
        next_counting = 1'b0;
        next_wave_active = 1'b0;
      end else if (trigger_mode && trigger_hit) begin
        next_counting = 1'b1;
        next_up_counter = `COUNTER_RESET;
        next_wave_active = 1'b0;
      end else if (counting && tick) begin
        next_up_counter = up_counter + `COUNTER_ONE;
        if (up_counter == wait_point_general_reg) begin
          next_wave_active = 1'b1;
          next_events[2] = 1'b1;
        end
        if (up_counter == end_point_general_reg) begin
          next_wave_active = 1'b0;
          next_events[1] = 1'b1;
        end
        if (up_counter == `COUNTER_MAX) begin
          next_events[3] = 1'b1;
        end
        if (up_counter == period_general_reg) begin
          next_events[0] = 1'b1;
          if (clear_select) begin
            next_up_counter = `COUNTER_RESET;
          end
          if (stop_on_match_select) begin
            next_counting = 1'b0;
            next_wave_active = 1'b0;
            if (!clear_select) begin
              next_up_counter = up_counter;
            end
          end
        end
      end
      // Software write of the counter overrides a same-cycle tick
      if (wr_fire && (aw_addr == `OFS_UP_COUNTER)) begin
        next_up_counter = CNT_WIDTH'(merge(32'(up_counter), w_data, w_strb));
      end
      next_wave_pin = next_wave_active ^ next_b_output_level_select;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      up_counter <= `COUNTER_RESET;
      counting <= 1'b0;
      wave_active <= 1'b0;
      wave_pin <= 1'b0;
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_prev <= 1'b0;
      events <= 4'h0;
    end else begin
      up_counter <= next_up_counter;
      counting <= next_counting;
      wave_active <= next_wave_active;
      wave_pin <= next_wave_pin;
      trig_s1 <= next_trig_s1;
      trig_s2 <= next_trig_s2;
      trig_prev <= next_trig_prev;
      events <= next_events;
    end
  end

  assign WAVEFORM_PIN_B     = wave_pin;
  assign MATCH_PERIOD_EVENT = events[0];
  assign MATCH_END_EVENT    = events[1];
  assign MATCH_WAIT_EVENT   = events[2];
  assign OVERFLOW_EVENT     = events[3];
  // Pin A never drives while it serves as the trigger input
  assign IO_PIN_A_OUT = port_a_data;
  assign IO_PIN_A_OE  = port_a_drive && (trigger_edge_sel == one_shot_wait_pulse_mode_pkg::EDGE_NONE);

  logic unused_bits;
  assign unused_bits = ^wr_word;

endmodule

`default_nettype wire

// ==== verilog/one_shot_wait_pulse_mode_consts.svh ====
// Register map, field positions, reset values and widths of the one-shot wait-pulse timer
`ifndef ONE_SHOT_WAIT_PULSE_MODE_CONSTS_SVH
`define ONE_SHOT_WAIT_PULSE_MODE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_TIMER_MODE_REG        8'h00
`define OFS_TIMER_CONTROL_ONE     8'h04
`define OFS_TIMER_CONTROL_TWO     8'h08
`define OFS_UP_COUNTER            8'h0c
`define OFS_PERIOD_GENERAL_REG    8'h10
`define OFS_END_POINT_GENERAL_REG 8'h14
`define OFS_WAIT_POINT_GENERAL_REG 8'h18
`define OFS_PORT_A_CONTROL        8'h1c
`define OFS_TIMER_STATUS          8'h20

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_RUN                   0
`define BIT_OUTPUT_LEVEL_B        1
`define LSB_COUNT_SOURCE          4
`define MSB_COUNT_SOURCE          6
`define BIT_CLEAR_SELECT          7
`define BIT_STOP_ON_MATCH         5
`define LSB_TRIGGER_EDGE          6
`define MSB_TRIGGER_EDGE          7
`define FIXED_ONES_CONTROL_TWO    32'h0000_0018
`define BIT_PORT_A_DATA           0
`define BIT_PORT_A_DRIVE          1
`define BIT_PORT_A_LEVEL          2
`define BIT_STATUS_COUNTING       0
`define BIT_STATUS_WAVE           1

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define GENERAL_REG_RESET         16'hffff
`define COUNTER_RESET             16'h0000
`define COUNTER_MAX               16'hffff
`define COUNTER_ONE               16'h0001
`define AXI_RESP_OKAY             2'b00
`define AXI_RESP_SLVERR           2'b10

`endif

// ==== verilog/one_shot_wait_pulse_mode_pkg.sv ====
// Types shared by the one-shot wait-pulse timer files
package one_shot_wait_pulse_mode_pkg;

  typedef enum logic [2:0] {
    SRC_DIV1      = 3'h0,
    SRC_DIV2      = 3'h1,
    SRC_DIV4      = 3'h2,
    SRC_DIV8      = 3'h3,
    SRC_DIV32     = 3'h4,
    SRC_EXT_PIN   = 3'h5,
    SRC_OSC_FAST  = 3'h6,
    SRC_OSC_DIV   = 3'h7
  } count_source_e;

  typedef enum logic [1:0] {
    EDGE_NONE    = 2'h0,
    EDGE_RISING  = 2'h1,
    EDGE_FALLING = 2'h2,
    EDGE_BOTH    = 2'h3
  } trigger_edge_e;

endpackage

// ==== verilog/one_shot_wait_pulse_mode_tick_source.sv ====
// Count source selection: system clock prescaler and synchronised clock pins
`timescale 1ns/100ps
`default_nettype none

module one_shot_wait_pulse_mode_tick_source #(
  parameter int DIV_WIDTH = 5
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire one_shot_wait_pulse_mode_pkg::count_source_e sel,
  input  wire logic                   ext_clk,
  input  wire logic                   osc_fast,
  input  wire logic                   osc_div,
  output logic                        tick
);

  logic [DIV_WIDTH-1:0] div_cnt;
  logic [DIV_WIDTH-1:0] next_div_cnt;
  logic [2:0]           sync_a;
  logic [2:0]           sync_b;
  logic [2:0]           prev_c;
  logic [2:0]           next_sync_a;
  logic [2:0]           next_sync_b;
  logic [2:0]           next_prev_c;
  logic [2:0]           rise;

  // Tick on the cycle where the low bits of the prescaler are all ones
  function automatic logic div_hit(input logic [DIV_WIDTH-1:0] cnt, input int bits);
    logic [DIV_WIDTH-1:0] mask;
    mask = DIV_WIDTH'((1 << bits) - 1);
    div_hit = ((cnt & mask) == mask);
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers, edge detect compares the second stage with its one-cycle-delayed copy
  // --------------------------------------------------------------------------
  always_comb begin
    next_sync_a = sync_a;
    next_sync_b = sync_b;
    next_prev_c = prev_c;
    next_div_cnt = div_cnt;
    if (ce) begin
      next_sync_a = {osc_div, osc_fast, ext_clk};
      next_sync_b = sync_a;
      next_prev_c = sync_b;
      next_div_cnt = div_cnt + DIV_WIDTH'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a  <= 3'h0;
      sync_b  <= 3'h0;
      prev_c  <= 3'h0;
      div_cnt <= '0;
    end else begin
      sync_a  <= next_sync_a;
      sync_b  <= next_sync_b;
      prev_c  <= next_prev_c;
      div_cnt <= next_div_cnt;
    end
  end

  assign rise = sync_b & ~prev_c;

  // --------------------------------------------------------------------------
  // Source select
  // --------------------------------------------------------------------------
  always_comb begin
    case (sel)
      one_shot_wait_pulse_mode_pkg::SRC_DIV1:     tick = ce;
      one_shot_wait_pulse_mode_pkg::SRC_DIV2:     tick = ce && div_hit(div_cnt, 1);
      one_shot_wait_pulse_mode_pkg::SRC_DIV4:     tick = ce && div_hit(div_cnt, 2);
      one_shot_wait_pulse_mode_pkg::SRC_DIV8:     tick = ce && div_hit(div_cnt, 3);
      one_shot_wait_pulse_mode_pkg::SRC_DIV32:    tick = ce && div_hit(div_cnt, 5);
      one_shot_wait_pulse_mode_pkg::SRC_EXT_PIN:  tick = ce && rise[0];
      one_shot_wait_pulse_mode_pkg::SRC_OSC_FAST: tick = ce && rise[1];
      default:                tick = ce && rise[2];
    endcase
  end

endmodule

`default_nettype wire

// ==== bench/one_shot_wait_pulse_mode_timer_assertions.sv ====
// Handshake and event assertions for the one-shot wait-pulse timer
`timescale 1ns/100ps
`default_nettype none
module one_shot_wait_pulse_mode_timer_assertions (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic AWREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic MATCH_END_EVENT,
  input wire logic MATCH_WAIT_EVENT,
  input wire logic OVERFLOW_EVENT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID) else $error("Response dropped");
  r_hold_a: assert property (RVALID && !RREADY |=> RVALID) else $error("Read data dropped");
  b_once_a: assert property (BVALID && BREADY |=> !BVALID) else $error("Response repeated");
  r_once_a: assert property (RVALID && RREADY |=> !RVALID) else $error("Read repeated");
  ar_block_a: assert property (RVALID |-> !ARREADY) else $error("Read taken while busy");
  aw_block_a: assert property (BVALID |-> !AWREADY) else $error("Write taken while busy");
  rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID) else $error("Read answer late");
  end_pulse_a: assert property (MATCH_END_EVENT |=> !MATCH_END_EVENT)
    else $error("Event longer than a cycle");
  wait_pulse_a: assert property (MATCH_WAIT_EVENT |=> !MATCH_WAIT_EVENT)
    else $error("Wait event longer than a cycle");
  ovf_pulse_a: assert property (OVERFLOW_EVENT |=> !OVERFLOW_EVENT)
    else $error("Overflow event longer than a cycle");
endmodule
`default_nettype wire

// ==== bench/one_shot_wait_pulse_mode_trig_src.sv ====
// Trigger source on pin A, sharing the wire with the port driver
`timescale 1ns/100ps
`default_nettype none
module one_shot_wait_pulse_mode_trig_src (
  input  wire logic clk,
  input  wire logic lvl,
  input  wire logic oe,
  input  wire logic out,
  output logic      pin
);
  // Device drive wins while enabled, else the source level
  always_ff @(posedge clk) pin <= oe ? out : lvl;
endmodule
`default_nettype wire

// ==== bench/test_timer_one_shot_wait_pulse_mode_one_shot_mode.sv ====
// Self-checking bench for the one-shot wait-pulse timer
`timescale 1ns/100ps
`default_nettype none
`include "one_shot_wait_pulse_mode_consts.svh"
module test_timer_one_shot_wait_pulse_mode_one_shot_mode;
  logic CLK_SYS = 0, SYS_RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic [7:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0, d, RDATA;
  logic [1:0] r, RRESP, BRESP;
  logic ovf;
  logic trig = 0, lvl, AWREADY, WREADY, BVALID, ARREADY, RVALID, wave, pev, pin_a, a_out, a_oe;
  int fails = 0, n_checks = 0, cyc = 0, n_ovf = 0, p, n, m, k, t, u;
  always #50 CLK_SYS = ~CLK_SYS;
  one_shot_wait_pulse_mode_timer DUT (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CLK_EN(1'b1), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .IO_PIN_A_IN(pin_a), .IO_PIN_A_OUT(a_out), .IO_PIN_A_OE(a_oe),
    .EXTERNAL_COUNT_CLOCK_PIN(1'b0), .FAST_OSC_40MHZ_CLOCK(1'b0), .FAST_OSC_DIVIDED_CLOCK(1'b0),
    .WAVEFORM_PIN_B(wave), .MATCH_PERIOD_EVENT(pev), .MATCH_END_EVENT(), .MATCH_WAIT_EVENT(),
    .OVERFLOW_EVENT(ovf));
  one_shot_wait_pulse_mode_trig_src TRIG (.clk(CLK_SYS), .lvl(trig), .oe(a_oe), .out(a_out), .pin(pin_a));
  task stop_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  always @(posedge CLK_SYS) if (ovf === 1'b1) n_ovf++;
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %0h got %0h", s, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw;
    @(posedge CLK_SYS);
    {AWADDR, WDATA, AWVALID, WVALID, BREADY} <= {a, v, 3'b111};
    pa = 1;
    pw = 1;
    while (pa || pw) begin
      @(posedge CLK_SYS);
      if (pa && AWREADY === 1) {pa, AWVALID} <= 2'b00;
      if (pw && WREADY === 1) {pw, WVALID} <= 2'b00;
      #1;
    end
    while (BVALID !== 1) @(posedge CLK_SYS);
    r = BRESP;
    BREADY <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge CLK_SYS);
    {ARADDR, ARVALID, RREADY} <= {a, 2'b11};
    do @(posedge CLK_SYS); while (ARREADY !== 1);
    ARVALID <= 0;
    do @(posedge CLK_SYS); while (RVALID !== 1);
    {d, r} = {RDATA, RRESP};
    RREADY <= 0;
  endtask
  // Cycles until the period event or the pin reaches v
  task wt(input logic s, input logic v, output int c);
    c = 0;
    do begin
      @(posedge CLK_SYS);
      c++;
    end while ((s ? pev : wave) !== v);
  endtask
  initial begin
    void'($urandom(32'hc1918112));
    repeat (6) @(posedge CLK_SYS);
    SYS_RST <= 0;
    rd(8'hfc);
    chk("unmapped resp", `AXI_RESP_SLVERR, r);
    wr(8'hfc, 0);
    chk("unmapped wr", `AXI_RESP_SLVERR, r);
    for (k = 0; k < 2; k++) begin
      lvl = k;
      p = 2 + $urandom % 6;
      n = k ? p + 1 : p + 2 + $urandom % 20; // Second pass: one-tick width
      m = n + 3 + $urandom % 10;
      wr(`OFS_TIMER_MODE_REG, 0);
      wr(`OFS_TIMER_CONTROL_ONE, 32'h80 | k << 4 | k << 1);
      wr(`OFS_TIMER_CONTROL_TWO, 0);
      wr(`OFS_PERIOD_GENERAL_REG, m);
      wr(`OFS_END_POINT_GENERAL_REG, n);
      wr(`OFS_WAIT_POINT_GENERAL_REG, p);
      // Start below the new period, else the count runs through a full wrap
      wr(`OFS_UP_COUNTER, 0);
      wr(`OFS_TIMER_MODE_REG, 1);
      wt(1, 1, t);
      wt(0, !lvl, t);
      chk("wait", (p + 1) * (k + 1), t);
      wt(0, lvl, t);
      chk("width", (n - p) * (k + 1), t);
      wt(0, !lvl, u);
      chk("period", (m + 1) * (k + 1), t + u);
      wr(`OFS_TIMER_MODE_REG, 0);
      repeat (2) @(posedge CLK_SYS);
      chk("stop level", lvl, wave);
      rd(`OFS_UP_COUNTER);
      t = d;
      rd(`OFS_UP_COUNTER);
      chk("counter kept", t, d);
    end
    wr(`OFS_PERIOD_GENERAL_REG, 60);
    for (k = 1; k < 4; k++) begin
      wr(`OFS_TIMER_MODE_REG, 0);
      trig <= (k == 2);
      wr(`OFS_TIMER_CONTROL_TWO, k << 6 | 32'h20);
      wr(`OFS_TIMER_MODE_REG, 1);
      rd(`OFS_TIMER_STATUS);
      chk("no start", 0, d[0]);
      trig <= !trig;
      repeat (8) @(posedge CLK_SYS);
      rd(`OFS_TIMER_STATUS);
      chk("triggered", 1, d[0]);
      wt(1, 1, t);
      repeat (2) @(posedge CLK_SYS);
      rd(`OFS_UP_COUNTER);
      chk("cleared", 0, d);
      rd(`OFS_TIMER_STATUS);
      chk("stopped", 0, d[1:0]);
    end
    wr(`OFS_TIMER_MODE_REG, 0);
    wr(`OFS_TIMER_CONTROL_TWO, 0);
    wr(`OFS_PORT_A_CONTROL, 3);
    chk("port a", 3, {a_oe, a_out});
    wr(`OFS_UP_COUNTER, 32'hfff0);
    wr(`OFS_TIMER_MODE_REG, 1);
    repeat (40) @(posedge CLK_SYS);
    chk("overflow", 1, n_ovf);
    stop_test();
  end
endmodule
bind one_shot_wait_pulse_mode_timer one_shot_wait_pulse_mode_timer_assertions CHK (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
  .AWREADY(AWREADY), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RVALID(RVALID), .RREADY(RREADY), .MATCH_END_EVENT(MATCH_END_EVENT),
  .MATCH_WAIT_EVENT(MATCH_WAIT_EVENT), .OVERFLOW_EVENT(OVERFLOW_EVENT));
`default_nettype wire
